//--- pkg/hostport_pkg.sv
// Constants shared by the host bus port and its FIFO
package hostport_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 7;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam int CNT_W = 16;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [1:0] SEL_LATCH = 2'h0;
   localparam logic [1:0] SEL_TXLVL = 2'h1;
   localparam logic [1:0] SEL_RXLVL = 2'h2;
   localparam logic [1:0] SEL_FREE = 2'h3;
   localparam int CSL_NS = 32;
   localparam int CLK_NS = 100;
   localparam int CSL_CYC = (CSL_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- src/word_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [AW:0] level_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic push, pop;
   logic [WIDTH-1:0] rd_data_r, rd_data_nxt;
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
      rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
      // Bypass keeps the head register right when a word lands on the new head slot
      rd_data_nxt = mem[rp_nxt[AW-1:0]];
      if (push && wp_r[AW-1:0] == rp_nxt[AW-1:0]) begin
         rd_data_nxt = in_data_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_r <= '0;
         rp_r <= '0;
         rd_data_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         rd_data_r <= rd_data_nxt;
      end
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data_i;
      end
   end
   assign level_o = wp_r - rp_r;
   assign in_ready_o = level_o != (AW+1)'(DEPTH);
   assign out_valid_o = level_o != '0;
   assign out_data_o = rd_data_r;
endmodule

//--- src/host_bus_port.sv
// Strobe-delimited host bus port with direct receive and transmit FIFO access
// Function
// - FIFO select burst reads return receive data
// - Direct receive mode chosen by select at read cycle start
// - Decode A[2:1], any change of A[7:1] steps FIFO burst reads
// - Direct bursts have no length limit
// - Read cycle: both low, ends either rises
// - All writes use the strobe write cycle
// - Write cycle: both low, ends either rises
// - FIFO select writes fill transmit FIFO
// - Select sampled once at cycle start, like A[2:1]
// - Data bus is 16 bits wide
// - Write data captured at cycle end
// - Counters latched at read cycle start
module host_bus_port (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic CHIP_SELECT_N_I,
   input wire logic READ_STROBE_N_I,
   input wire logic WRITE_STROBE_N_I,
   input wire logic [hostport_pkg::ADDR_W:1] ADDR_I,
   input wire logic FIFO_SEL_I,
   input wire logic [hostport_pkg::DATA_W-1:0] DATA_I,
   output logic [hostport_pkg::DATA_W-1:0] DATA_O,
   output logic DATA_OE_N_O,
   input wire logic RX_VALID_I,
   input wire logic [hostport_pkg::DATA_W-1:0] RX_DATA_I,
   output logic RX_READY_O,
   output logic TX_VALID_O,
   output logic [hostport_pkg::DATA_W-1:0] TX_DATA_O,
   input wire logic TX_READY_I,
   output logic REG_WR_O,
   output logic [1:0] REG_ADDR_O,
   output logic [hostport_pkg::DATA_W-1:0] REG_DATA_O,
   input wire logic [hostport_pkg::CNT_W-1:0] COUNTER_I,
   output logic TX_FULL_O
);
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READ = 2'b01, ST_WRITE = 2'b10} bus_e;

   function automatic logic [1:0] lane_sel(input logic [hostport_pkg::ADDR_W:1] a);
      return a[2:1];
   endfunction

   bus_e st_r, st_nxt;
   logic [hostport_pkg::DATA_W-1:0] dout_r, dout_nxt, wdat_r, wdat_nxt;
   logic oe_n_r, oe_n_nxt, fsel_r, fsel_nxt, rx_pop_r, rx_pop_nxt;
   logic tx_push_r, tx_push_nxt, reg_wr_r, reg_wr_nxt, full_r;
   logic [1:0] a_r, a_nxt;
   logic [hostport_pkg::ADDR_W:1] addr_last_r, addr_last_nxt;
   logic [hostport_pkg::CNT_W-1:0] cnt_lat_r, cnt_lat_nxt;
   logic rd_act, wr_act;
   logic tx_in_ready, tx_out_valid, tx_take;
   logic [hostport_pkg::DATA_W-1:0] tx_out_data;
   logic [hostport_pkg::FIFO_AW:0] tx_level;

   assign rd_act = !CHIP_SELECT_N_I && !READ_STROBE_N_I;
   assign wr_act = !CHIP_SELECT_N_I && !WRITE_STROBE_N_I;

   always_comb begin
      st_nxt = st_r;
      dout_nxt = dout_r;
      oe_n_nxt = 1'b1;
      fsel_nxt = fsel_r;
      a_nxt = a_r;
      wdat_nxt = wdat_r;
      addr_last_nxt = addr_last_r;
      cnt_lat_nxt = cnt_lat_r;
      rx_pop_nxt = 1'b0;
      tx_push_nxt = 1'b0;
      reg_wr_nxt = 1'b0;
      unique case (st_r)
         ST_IDLE: begin
            if (rd_act) begin
               st_nxt = ST_READ;
               oe_n_nxt = 1'b0;
               fsel_nxt = FIFO_SEL_I;
               a_nxt = lane_sel(ADDR_I);
               addr_last_nxt = ADDR_I;
               cnt_lat_nxt = COUNTER_I;
               if (FIFO_SEL_I) begin
                  dout_nxt = RX_DATA_I;
                  rx_pop_nxt = RX_VALID_I;
               end else begin
                  dout_nxt = COUNTER_I;
               end
            end else if (wr_act) begin
               st_nxt = ST_WRITE;
               fsel_nxt = FIFO_SEL_I;
               a_nxt = lane_sel(ADDR_I);
            end
         end
         ST_READ: begin
            oe_n_nxt = !rd_act;
            if (!rd_act) begin
               st_nxt = ST_IDLE;
            end else if (fsel_r && ADDR_I != addr_last_r) begin
               addr_last_nxt = ADDR_I;
               dout_nxt = RX_DATA_I;
               rx_pop_nxt = RX_VALID_I;
            end else if (!fsel_r) begin
               dout_nxt = cnt_lat_r;
            end
         end
         ST_WRITE: begin
            wdat_nxt = DATA_I;
            if (!wr_act) begin
               st_nxt = ST_IDLE;
               tx_push_nxt = fsel_r;
               reg_wr_nxt = !fsel_r;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         st_r <= ST_IDLE;
         dout_r <= hostport_pkg::DATA_RST;
         oe_n_r <= 1'b1;
         fsel_r <= 1'b0;
         a_r <= hostport_pkg::SEL_LATCH;
         wdat_r <= hostport_pkg::DATA_RST;
         addr_last_r <= '0;
         cnt_lat_r <= hostport_pkg::CNT_RST;
         rx_pop_r <= 1'b0;
         tx_push_r <= 1'b0;
         reg_wr_r <= 1'b0;
         full_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
         fsel_r <= fsel_nxt;
         a_r <= a_nxt;
         wdat_r <= wdat_nxt;
         addr_last_r <= addr_last_nxt;
         cnt_lat_r <= cnt_lat_nxt;
         rx_pop_r <= rx_pop_nxt;
         tx_push_r <= tx_push_nxt;
         reg_wr_r <= reg_wr_nxt;
         full_r <= !tx_in_ready;
      end
   end

   word_fifo #(
      .WIDTH(hostport_pkg::DATA_W),
      .DEPTH(hostport_pkg::FIFO_DEPTH),
      .AW(hostport_pkg::FIFO_AW)
   ) tx_fifo (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .in_valid_i(tx_push_r),
      .in_ready_o(tx_in_ready),
      .in_data_i(wdat_r),
      .out_valid_o(tx_out_valid),
      .out_ready_i(tx_take),
      .out_data_o(tx_out_data),
      .level_o(tx_level)
   );

   logic tx_v_r, tx_v_nxt;
   logic [hostport_pkg::DATA_W-1:0] tx_d_r, tx_d_nxt;
   // Output register refills only when empty or when its word is taken
   always_comb begin
      tx_take = !tx_v_r || TX_READY_I;
      tx_v_nxt = tx_v_r;
      tx_d_nxt = tx_d_r;
      if (tx_take) begin
         tx_v_nxt = tx_out_valid;
         if (tx_out_valid) begin
            tx_d_nxt = tx_out_data;
         end
      end
   end
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         tx_v_r <= 1'b0;
         tx_d_r <= hostport_pkg::DATA_RST;
      end else begin
         tx_v_r <= tx_v_nxt;
         tx_d_r <= tx_d_nxt;
      end
   end

   assign DATA_O = dout_r;
   assign DATA_OE_N_O = oe_n_r;
   assign RX_READY_O = rx_pop_r;
   assign TX_VALID_O = tx_v_r;
   assign TX_DATA_O = tx_d_r;
   assign REG_WR_O = reg_wr_r;
   assign REG_ADDR_O = a_r;
   assign REG_DATA_O = wdat_r;
   assign TX_FULL_O = full_r;

   property wr_push_p;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_WRITE && !wr_act && fsel_r) |=> tx_push_r;
   endproperty
   write_to_fifo_a: assert property (wr_push_p) else $error("fifo write lost");
   sequence rd_start_s;
      st_r == ST_IDLE && rd_act;
   endsequence
   read_drive_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      rd_start_s |=> !oe_n_r) else $error("read not driven");
   read_end_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_READ && !rd_act) |=> oe_n_r) else $error("read not ended");
   rx_select_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (rd_start_s ##0 FIFO_SEL_I) |=> dout_r == $past(RX_DATA_I))
      else $error("rx data not returned");
   no_rx_pop_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (rd_start_s ##0 !FIFO_SEL_I) |=> !rx_pop_r) else $error("rx popped");
   cnt_latch_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (rd_start_s ##0 !FIFO_SEL_I) |=> cnt_lat_r == $past(COUNTER_I))
      else $error("counter not latched");
   wr_capture_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_WRITE && !wr_act) |=> wdat_r == $past(DATA_I))
      else $error("write data wrong");
   reg_write_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_WRITE && !wr_act && !fsel_r) |=> reg_wr_r && !tx_push_r)
      else $error("register write wrong");
   step_pop_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_READ && rd_act && fsel_r && ADDR_I == addr_last_r) |=> !rx_pop_r)
      else $error("duplicate pop");
   read_stable_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (st_r == ST_READ && rd_act && !fsel_r) |=> $stable(dout_r))
      else $error("read data moved");
   tx_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      (tx_v_r && !TX_READY_I) |=> tx_v_r && $stable(tx_d_r))
      else $error("transmit word dropped");
endmodule

//--- tb/host_model.sv
// Host processor model on the strobe-delimited bus
module host_model (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   input wire logic oe_n_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic sel_o,
   output logic [7:1] addr_o,
   output logic [15:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      sel_o = 1'b0;
      addr_o = 7'h00;
      wdata_o = 16'h0000;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Write data held until both strobes are high again
   task automatic wr(input logic s, input logic [7:1] a, input logic [15:0] d, input bit by_cs);
      sel_o = s;
      addr_o = a;
      wdata_o = d;
      cs_n_o = 1'b0;
      wr_n_o = 1'b0;
      gap(2);
      if (by_cs) cs_n_o = 1'b1;
      else wr_n_o = 1'b1;
      gap(1);
      cs_n_o = 1'b1;
      wr_n_o = 1'b1;
      gap(1);
      wdata_o = ~d;
      gap(1);
   endtask
   // Burst read, upper address bits step on every beat after the first
   task automatic rd(input logic s, input logic [7:1] a, input int n, input bit by_cs,
                     ref logic [16:0] q[$]);
      sel_o = s;
      addr_o = a;
      cs_n_o = 1'b0;
      rd_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (i > 0) addr_o = addr_o + 7'h04;
         gap(2);
         q.push_back({oe_n_i, rdata_i});
         gap(1);
         q.push_back({oe_n_i, rdata_i});
      end
      if (by_cs) cs_n_o = 1'b1;
      else rd_n_o = 1'b1;
      gap(1);
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      gap(2);
   endtask
endmodule

//--- tb/testbench.sv
// Bench for the host bus port with receive source and transmit sink models
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   logic cs_n, rd_n, wr_n, fsel, oe_n, rx_ready, tx_valid, reg_wr, tx_full;
   logic rx_valid = 1'b0, tx_ready = 1'b0, stall = 1'b1, prev_idle = 1'b1, rdy = 1'b0;
   logic [7:1] addr;
   logic [1:0] reg_addr;
   logic [15:0] wdata, rdata, tx_data, reg_data, wv, lat;
   logic [15:0] rx_data = 16'h0000, counter = 16'h0000;
   logic [16:0] got[$];
   logic [17:0] tx_q[$], reg_q[$];
   logic [15:0] rx_q[$], exp_rx[$];
   int mismatches = 0, samples_checked = 0, cycles = 0, pops = 0, p0, txn = 0;
   int lens[3] = '{1, 3, 20};
   always #50 MCLK_I = ~MCLK_I;
   host_model host (.clk_i(MCLK_I), .rdata_i(rdata), .oe_n_i(oe_n), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(fsel), .addr_o(addr), .wdata_o(wdata));
   host_bus_port DUT (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .CHIP_SELECT_N_I(cs_n),
      .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n), .ADDR_I(addr), .FIFO_SEL_I(fsel),
      .DATA_I(wdata), .DATA_O(rdata), .DATA_OE_N_O(oe_n), .RX_VALID_I(rx_valid),
      .RX_DATA_I(rx_data), .RX_READY_O(rx_ready), .TX_VALID_O(tx_valid),
      .TX_DATA_O(tx_data), .TX_READY_I(tx_ready), .REG_WR_O(reg_wr),
      .REG_ADDR_O(reg_addr), .REG_DATA_O(reg_data), .COUNTER_I(counter),
      .TX_FULL_O(tx_full));
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Idle levels of every output after reset
   task automatic reset_check();
      check({13'h0, oe_n, rx_ready, tx_valid, reg_wr, tx_full}, 18'h00010);
      check({reg_addr, rdata | tx_data | reg_data}, 18'h00000);
   endtask
   // Sink, register and source models act between clock edges
   always @(negedge MCLK_I) begin
      rdy = !stall && 1'($urandom);
      if (tx_valid === 1'b1 && rdy) begin
         check({2'b00, tx_data}, tx_q.size() ? tx_q.pop_front() : 'x);
      end
      if (reg_wr === 1'b1) begin
         check({reg_addr, reg_data}, reg_q.size() ? reg_q.pop_front() : 'x);
      end
      if (rx_ready === 1'b1 && rx_valid) begin
         void'(rx_q.pop_front());
         pops++;
      end
      rx_valid <= rx_q.size() > 0;
      rx_data <= rx_q.size() ? rx_q[0] : ~rx_data;
      tx_ready <= rdy;
      counter <= 16'($urandom);
   end
   always @(posedge MCLK_I) begin
      if (!cs_n && !rd_n && prev_idle) lat <= counter;
      prev_idle <= cs_n | rd_n;
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(32'h908AF48A));
      for (int i = 0; i < 40; i++) begin
         rx_q.push_back(16'($urandom));
         exp_rx.push_back(rx_q[i]);
      end
      repeat (6) @(negedge MCLK_I);
      SYS_RST_I = 1'b0;
      host.gap(1);
      reset_check();
      foreach (lens[k]) begin
         p0 = pops;
         host.rd(1'b1, {5'($urandom), 2'b00}, lens[k], k[0], got);
         for (int j = 0; j < lens[k]; j++) begin
            check(18'(got.pop_front()), {2'b00, exp_rx[0]});
            check(18'(got.pop_front()), {2'b00, exp_rx.pop_front()});
         end
         check(18'(pops - p0), 18'(lens[k]));
         check(18'(oe_n), 18'h1);
      end
      for (int k = 0; k < 3; k++) begin
         host.rd(1'b0, 7'h00, 1, k[0], got);
         check(18'(got.pop_front()), {2'b00, lat});
         check(18'(got.pop_front()), {2'b00, lat});
      end
      for (int k = 0; k < 4; k++) begin
         wv = 16'($urandom);
         reg_q.push_back({2'(k), wv});
         host.wr(1'b0, {5'h00, 2'(k)}, wv, k[0]);
      end
      // Stalled sink: FIFO depth plus the output register hold words
      for (int k = 0; k < 18; k++) begin
         wv = 16'($urandom);
         check(18'(tx_full), 18'(txn > hostport_pkg::FIFO_DEPTH));
         if (txn <= hostport_pkg::FIFO_DEPTH) begin
            tx_q.push_back({2'b00, wv});
            txn++;
         end
         host.wr(1'b1, {5'($urandom), 2'b00}, wv, k[0]);
      end
      check(18'(tx_full), 18'h1);
      stall = 1'b0;
      host.gap(120);
      check(18'(tx_q.size() + reg_q.size()), 18'h0);
      SYS_RST_I = 1'b1;
      host.gap(2);
      SYS_RST_I = 1'b0;
      host.gap(1);
      reset_check();
      p0 = pops;
      host.rd(1'b1, 7'h7C, 2, 1'b0, got);
      for (int j = 0; j < 2; j++) begin
         check(18'(got.pop_front()), {2'b00, exp_rx[0]});
         check(18'(got.pop_front()), {2'b00, exp_rx.pop_front()});
      end
      check(18'(pops - p0), 18'h2);
      print_verdict();
   end
endmodule
